//--- logic/afs_supervisor.sv
// afs_supervisor: global and per-channel fault supervisor for a four-channel amplifier
// assumes analog comparators deliver fault levels asynchronously; host commands are same-clock levels
`timescale 1ns/1ps
`default_nettype none
module afs_supervisor
  import afs_pkg::*;
#(
  parameter int OC_TIMER_CYC = 16'h0400  // current limit persistence before overcurrent
)(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // analog fault comparators (asynchronous)
  input wire logic POR_FAULT,
  input wire logic UNDERVOLTAGE,
  input wire logic CHARGE_PUMP_UNDERVOLTAGE,
  input wire logic SUPPLY_EXCESS_FAULT,
  input wire logic LOAD_DUMP,
  input wire logic OVERTEMP_WARNING,
  input wire logic OVERTEMP_SHUTDOWN,
  input wire logic [3:0] CLIP_DETECT,
  input wire logic [3:0] CYCLE_BY_CYCLE_LIMIT,
  input wire logic [3:0] DC_DETECT,
  input wire logic [3:0] DIAG_RESULT,
  input wire logic TWEETER_PRESENT,
  input wire logic [7:0] MUTE_PIN_LEVEL,
  // host commands (same clock)
  input wire logic [3:0] CMD_HIZ,
  input wire logic CMD_PLAY,
  input wire logic CMD_DIAG_START,
  input wire logic CMD_TWEETER_DIAG,
  input wire logic CMD_FAULT_CLEAR,
  input wire logic [1:0] WARN_SEL,
  input wire logic PLAY_AT_9_10,
  // operating state
  output logic [1:0] MODE,
  output logic [3:0] CH_HIZ,
  output logic [3:0] CH_HARD_MUTE,
  output logic [3:0] CUR_LIMIT,
  output logic [7:0] GAIN,
  output logic MUTE_DRIVE,
  // status for the host
  output logic [6:0] GLOBAL_STATUS,
  output logic [3:0] OC_STATUS,
  output logic [3:0] DC_STATUS,
  output logic [3:0] DIAG_STATUS,
  output logic MUTE_ENTERED,
  output logic PLAY_ENTERED,
  // pins, open drain: oe low while pulling low
  output logic FAULT_N_O,
  output logic FAULT_N_OE,
  output logic CLIP_OR_HEAT_WARN_N
);
  localparam int NS = 8 + 4 * NUM_CH;  // eight global levels plus four per-channel groups
  typedef struct packed
  {
    logic uv;                 // latched voltage faults
    logic charge_pump_undervoltage;
    logic sx;
    logic ots;                // latched heat shutdown
    logic [3:0] oc;           // latched channel overcurrent
    logic [3:0] dc;           // latched dc level
    logic [3:0] diag;         // latched diagnostic result
    logic [3:0] hiz;          // host Hi-Z request
    logic play;               // host play request
    logic [15:0] oc_cnt0;
    logic [15:0] oc_cnt1;
    logic [15:0] oc_cnt2;
    logic [15:0] oc_cnt3;
    logic fault;              // registered fault pin state
    logic warn;               // registered clip pin state
  } afs_sup_s;
  afs_sup_s st, next_st;
  logic [NS-1:0] raw, syn;
  logic por, uv, cpuv, sx, ld, overtemp_warning, ots, tw;
  logic [3:0] clip, cbc, dcd, diag;
  logic standby, glob_hiz, normal, any_fault, diag_ok, mon_mode;
  logic [3:0] oc_hit;
  logic [15:0] cnt [NUM_CH];
  logic [1:0] mode;
  // all asynchronous comparator levels except MUTE_PIN_LEVEL pass the three-stage filter
  assign raw = {POR_FAULT, UNDERVOLTAGE, CHARGE_PUMP_UNDERVOLTAGE, SUPPLY_EXCESS_FAULT,
                LOAD_DUMP, OVERTEMP_WARNING, OVERTEMP_SHUTDOWN, TWEETER_PRESENT,
                CLIP_DETECT, CYCLE_BY_CYCLE_LIMIT, DC_DETECT, DIAG_RESULT};
  afs_sync3 #(.W(NS)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .din(raw),
    .dout(syn)
  );
  assign {por, uv, cpuv, sx, ld, overtemp_warning, ots, tw, clip, cbc, dcd, diag} = syn;
  assign cnt[0] = st.oc_cnt0;
  assign cnt[1] = st.oc_cnt1;
  assign cnt[2] = st.oc_cnt2;
  assign cnt[3] = st.oc_cnt3;
  // mode resolution: standby faults dominate voltage faults
  always_comb
  begin
    standby = por || ld || st.ots;
    glob_hiz = st.uv || st.charge_pump_undervoltage || st.sx;
    if (standby)
    begin
      mode = AFS_STANDBY;
    end
    else if (glob_hiz || (&st.hiz))
    begin
      mode = AFS_HIZ;
    end
    else if (st.play)
    begin
      mode = AFS_NORMAL;
    end
    else
    begin
      mode = AFS_MUTE;
    end
    normal = (mode == AFS_NORMAL);
    mon_mode = (mode == AFS_HIZ) || (mode == AFS_MUTE) || normal;  // heat and voltage watched outside standby
    diag_ok = (mode == AFS_HIZ) && !glob_hiz;
    any_fault = standby || glob_hiz || (|st.oc) || (|st.dc);
  end
  // overcurrent timers run while the limit is active on a channel not in host Hi-Z, in mute or normal
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_oc
      assign oc_hit[c] = cnt[c] >= 16'(OC_TIMER_CYC - 1);
    end
  endgenerate
  // next state
  always_comb
  begin
    logic [15:0] nc [NUM_CH];
    next_st = st;
    for (int c = 0; c < NUM_CH; c++)
    begin
      nc[c] = 16'h0000;
    end
    // clear before the fault events, so a same-cycle event wins over the clear
    next_st.hiz = CMD_HIZ;
    next_st.play = CMD_PLAY;
    if (CMD_FAULT_CLEAR)
    begin
      next_st.uv = 1'b0;
      next_st.charge_pump_undervoltage = 1'b0;
      next_st.sx = 1'b0;
      next_st.ots = 1'b0;
      next_st.oc = 4'h0;
      next_st.dc = 4'h0;
      next_st.diag = 4'h0;
    end
    if (mon_mode)
    begin
      if (uv) next_st.uv = 1'b1;
      if (cpuv) next_st.charge_pump_undervoltage = 1'b1;
      if (sx) next_st.sx = 1'b1;
      if (ots) next_st.ots = 1'b1;
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      if ((mode == AFS_MUTE || normal) && !st.hiz[c] && cbc[c])
      begin
        nc[c] = oc_hit[c] ? cnt[c] : cnt[c] + 16'h0001;
        if (oc_hit[c]) next_st.oc[c] = 1'b1;
      end
      if (normal && dcd[c]) next_st.dc[c] = 1'b1;
      if (diag_ok && CMD_DIAG_START && diag[c]) next_st.diag[c] = 1'b1;
    end
    next_st.oc_cnt0 = nc[0];
    next_st.oc_cnt1 = nc[1];
    next_st.oc_cnt2 = nc[2];
    next_st.oc_cnt3 = nc[3];
    next_st.fault = any_fault;
    // clip pin source select, heat warning monitored outside standby
    next_st.warn = ((WARN_SEL[0] && mon_mode && overtemp_warning) ||
                    (WARN_SEL[1] && normal && (|clip)) ||
                    (mode == AFS_MUTE || normal) && (|(cbc & ~st.hiz)) ||
                    (CMD_TWEETER_DIAG && diag_ok && tw));
  end
  // register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  // gain ramp engine shared by all channels
  afs_ramp u_ramp (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .play_req(st.play && normal),
    .hard_mute(standby || glob_hiz),
    .play_at_9_10(PLAY_AT_9_10),
    .mute_pin(MUTE_PIN_LEVEL),
    .mute_drive(MUTE_DRIVE),
    .gain(GAIN),
    .mute_entered(MUTE_ENTERED),
    .play_entered(PLAY_ENTERED)
  );
  // outputs
  assign MODE = mode;
  assign CH_HIZ = {4{mode == AFS_STANDBY || mode == AFS_HIZ}} | st.hiz | st.oc | st.dc;
  assign CH_HARD_MUTE = {4{standby}} | st.oc | st.dc;
  assign CUR_LIMIT = cbc & {4{mode == AFS_MUTE || normal}};
  // status excludes the self-clearing power-on and load dump events
  assign GLOBAL_STATUS = {overtemp_warning, st.ots, st.sx, st.charge_pump_undervoltage, st.uv, 2'b00};
  assign OC_STATUS = st.oc;
  assign DC_STATUS = st.dc;
  assign DIAG_STATUS = st.diag;
  assign FAULT_N_O = 1'b0;
  assign FAULT_N_OE = !st.fault;
  assign CLIP_OR_HEAT_WARN_N = !st.warn;
  // checks on the supervisor's own outputs
  // power-on fault takes standby and hard mute, no ramp
  property p_por_standby;
    @(posedge CORE_CLK) disable iff (!RSTN)
    por |-> MODE == AFS_STANDBY && CH_HARD_MUTE == 4'hF;
  endproperty
  a_por_standby: assert property (p_por_standby) else $error("power-on fault without standby");
  // undervoltage survives until the host clears it
  property p_uv_latch;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (st.uv && !CMD_FAULT_CLEAR) |=> st.uv;
  endproperty
  a_uv_latch: assert property (p_uv_latch) else $error("undervoltage not latched");
  // latched heat shutdown keeps the device in standby
  property p_ots_standby;
    @(posedge CORE_CLK) disable iff (!RSTN)
    st.ots |-> MODE == AFS_STANDBY;
  endproperty
  a_ots_standby: assert property (p_ots_standby) else $error("heat shutdown without standby");
  // every forced standby or Hi-Z reaches the pin one edge later
  property p_fault_pin;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (standby || glob_hiz) |=> !FAULT_N_OE;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not pulled");
  // monitored voltage fault: latch with outputs Hi-Z, then the pin
  sequence s_volt_seen;
    (uv || cpuv || sx) && mon_mode;
  endsequence
  sequence s_volt_latched;
    glob_hiz && CH_HIZ == 4'hF;
  endsequence
  property p_volt_chain;
    @(posedge CORE_CLK) disable iff (!RSTN)
    s_volt_seen |=> s_volt_latched ##1 !FAULT_N_OE;
  endproperty
  a_volt_chain: assert property (p_volt_chain) else $error("voltage fault chain broken");
  // a channel latches overcurrent only once its limit timer ran out
  property p_oc_timer;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (st.oc & ~$past(st.oc)) != 4'h0 |-> $past(|(oc_hit & cbc));
  endproperty
  a_oc_timer: assert property (p_oc_timer) else $error("overcurrent latched before timer");
  // an overcurrent channel is both isolated and hard muted
  property p_oc_hiz;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (|st.oc) |-> (st.oc & ~(CH_HIZ & CH_HARD_MUTE)) == 4'h0;
  endproperty
  a_oc_hiz: assert property (p_oc_hiz) else $error("overcurrent channel not isolated");
  // dc level latches only from normal mode
  property p_dc_normal;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (st.dc & ~$past(st.dc)) != 4'h0 |-> $past(normal);
  endproperty
  a_dc_normal: assert property (p_dc_normal) else $error("dc detect outside normal");
  // diagnostic results latch only from Hi-Z mode
  property p_diag_hiz;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (st.diag & ~$past(st.diag)) != 4'h0 |-> $past(mode) == AFS_HIZ;
  endproperty
  a_diag_hiz: assert property (p_diag_hiz) else $error("diagnostic outside Hi-Z");
  // current limit on any live channel shows on the clip pin
  property p_cbc_pin;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (normal && |(cbc & ~st.hiz)) |=> !CLIP_OR_HEAT_WARN_N;
  endproperty
  a_cbc_pin: assert property (p_cbc_pin) else $error("limit not shown on clip pin");
endmodule
`default_nettype wire

//--- logic/afs_pkg.sv
// afs_pkg: shared constants and types for the amplifier fault supervisor
// assumes a single 50 MHz core clock and four output channels
package afs_pkg;
  localparam int NUM_CH = 4;                      // channel count
  localparam int CLK_MHZ = 50;                    // core clock rate
  localparam int ADC_W = 8;                       // mute pin sample width
  // mute pin thresholds as fractions of the bypass reference, in 1/30ths
  localparam logic [7:0] THR_2_3 = 8'h14;         // 20/30
  localparam logic [7:0] THR_1_3 = 8'h0A;         // 10/30
  localparam logic [7:0] THR_1_10 = 8'h03;        // 3/30
  localparam logic [7:0] THR_9_10 = 8'h1B;        // 27/30
  localparam logic [7:0] FRAC_DEN = 8'h1E;        // denominator 30
  localparam logic [1:0] RST_WARN_SEL = 2'h3;     // reset clip pin source: OR of both
  localparam logic RST_PLAY_AT_9_10 = 1'b1;       // play bit threshold after reset
  localparam logic [7:0] RST_GAIN = 8'h00;        // gain after reset
  localparam logic [7:0] GAIN_FULL = 8'hFF;       // full gain
  localparam logic [7:0] GAIN_STEP = 8'h01;       // gain step per ramp tick
  localparam int RAMP_TICK_NS = 1000;             // gain step interval
  localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + (1000 / CLK_MHZ) - 1) / (1000 / CLK_MHZ);
  // operating modes
  typedef enum logic [1:0] {AFS_STANDBY, AFS_HIZ, AFS_MUTE, AFS_NORMAL} afs_mode_e;
endpackage

//--- logic/afs_sync3.sv
// afs_sync3: three-stage synchroniser for asynchronous level inputs
// assumes the output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module afs_sync3
  import afs_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous input and filtered result
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed
  {
    logic [W-1:0] s1;   // first stage, read only by s2
    logic [W-1:0] s2;   // second stage
    logic [W-1:0] s3;   // third stage
    logic [W-1:0] q;    // agreed value
  } afs_sync_s;
  afs_sync_s st, next_st;
  // next value: agreement of stages two and three per bit
  always_comb
  begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.q[i] = st.s3[i];
      end
    end
  end
  // register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign dout = st.q;
endmodule
`default_nettype wire

//--- logic/afs_ramp.sv
// afs_ramp: mute/play gain ramp sequenced against mute pin voltage
// assumes the mute pin voltage arrives as a sampled 8-bit ratio of the bypass reference
`timescale 1ns/1ps
`default_nettype none
module afs_ramp
  import afs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic play_req,        // level: host wants play
  input wire logic hard_mute,       // fault forces gain to zero at once
  input wire logic play_at_9_10,    // chooses the play bit threshold
  input wire logic [7:0] mute_pin,  // sampled pin voltage in 1/30ths
  // results
  output logic mute_drive,          // 1: charge the mute pin towards play
  output logic [7:0] gain,
  output logic mute_entered,
  output logic play_entered
);
  typedef struct packed
  {
    logic [7:0] gain;
    logic [15:0] tick;
    logic mute_ent;
    logic play_ent;
  } afs_ramp_s;
  afs_ramp_s st, next_st;
  logic tick_p;
  logic [7:0] play_thr;
  // gain ramp rate from a one-cycle enable
  always_comb
  begin
    tick_p = (st.tick == 16'(RAMP_TICK_CYC - 1));
    play_thr = play_at_9_10 ? THR_9_10 : THR_2_3;
  end
  // gain follows pin voltage windows
  always_comb
  begin
    next_st = st;
    next_st.tick = tick_p ? 16'h0000 : st.tick + 16'h0001;
    if (hard_mute)
    begin
      next_st.gain = 8'h00;  // no ramp on forced mute
    end
    else if (!play_req && mute_pin <= THR_2_3 && mute_pin > THR_1_3 && tick_p && st.gain != 8'h00)
    begin
      next_st.gain = st.gain - GAIN_STEP;
    end
    else if (!play_req && mute_pin <= THR_1_3)
    begin
      next_st.gain = 8'h00;
    end
    else if (play_req && mute_pin >= THR_1_3 && tick_p && st.gain != GAIN_FULL)
    begin
      next_st.gain = st.gain + GAIN_STEP;
    end
    // status bits follow only their own pin levels
    if (!play_req && mute_pin <= THR_1_10)
    begin
      next_st.mute_ent = 1'b1;
      next_st.play_ent = 1'b0;
    end
    else if (play_req && mute_pin >= play_thr)
    begin
      next_st.play_ent = 1'b1;
      next_st.mute_ent = 1'b0;
    end
  end
  // register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign mute_drive = play_req;
  assign gain = st.gain;
  assign mute_entered = st.mute_ent;
  assign play_entered = st.play_ent;
  // below one third in mute the gain is gone
  property p_gain_zero_low;
    @(posedge clk) disable iff (!rst_n)
    (!play_req && mute_pin <= THR_1_3 && !hard_mute) |=> gain == 8'h00;
  endproperty
  a_gain_zero_low: assert property (p_gain_zero_low) else $error("gain not zero below one third");
  // mute bit waits for the pin to fall under one tenth
  property p_mute_bit;
    @(posedge clk) disable iff (!rst_n)
    $rose(mute_entered) |-> $past(mute_pin) <= THR_1_10;
  endproperty
  a_mute_bit: assert property (p_mute_bit) else $error("mute bit set above one tenth");
  // play bit never before two thirds, whichever threshold is chosen
  property p_play_bit;
    @(posedge clk) disable iff (!rst_n)
    $rose(play_entered) |-> $past(mute_pin) >= THR_2_3;
  endproperty
  a_play_bit: assert property (p_play_bit) else $error("play bit set too early");
  // no gain rise before the pin reaches one third
  property p_no_rise_low;
    @(posedge clk) disable iff (!rst_n)
    (play_req && mute_pin < THR_1_3) |=> !(gain > $past(gain));
  endproperty
  a_no_rise_low: assert property (p_no_rise_low) else $error("gain rose below one third");
endmodule
`default_nettype wire

//--- sim/afs_mute_cap.sv
// afs_mute_cap: behavioural mute capacitor as the pin sampler sees it
// assumes the device charges the pin while drive is high, discharges it otherwise
`timescale 1ns/1ps
`default_nettype none
module afs_mute_cap
  import afs_pkg::*;
#(
  parameter int STEP_CYC = 40  // cycles per 1/30 step, stands in for the capacitor value
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin drive and sensed level
  input wire logic drive,
  output logic [7:0] level
);
  int cnt;  // cycles since last step
  // linear slew instead of an exponential one, enough to cross every threshold in order
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      level <= 8'h00;
      cnt <= 0;
    end
    else if (cnt == STEP_CYC - 1)
    begin
      cnt <= 0;
      if (drive && level < FRAC_DEN)
        level <= level + 8'h01;  // charging towards play
      else if (!drive && level != 8'h00)
        level <= level - 8'h01;  // discharging towards mute
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

//--- sim/tb_afs_supervisor.sv
// tb_afs_supervisor: self-checking bench for the fault supervisor
// assumes afs_pkg and the mute capacitor model; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_afs_supervisor;
  import afs_pkg::*;
  // stimulus, global faults packed: 0 por,1 uv,2 pump,3 excess,4 dump,5 warn,6 shutdown
  logic CORE_CLK = 0, RSTN = 0, TWEETER_PRESENT = 0, CMD_PLAY = 0, CMD_DIAG_START = 0;
  logic CMD_TWEETER_DIAG = 0, CMD_FAULT_CLEAR = 0, PLAY_AT_9_10 = 1;
  logic [6:0] gf = 0;
  logic [3:0] CLIP_DETECT = 0, CYCLE_BY_CYCLE_LIMIT = 0, DC_DETECT = 0, DIAG_RESULT = 0, CMD_HIZ = 0;
  logic [1:0] WARN_SEL = 2'h3;
  // observed outputs
  logic [1:0] MODE;
  logic [3:0] CH_HIZ, CH_HARD_MUTE, CUR_LIMIT, OC_STATUS, DC_STATUS, DIAG_STATUS;
  logic [7:0] GAIN, MUTE_PIN_LEVEL;
  logic [6:0] GLOBAL_STATUS;
  logic MUTE_DRIVE, MUTE_ENTERED, PLAY_ENTERED, FAULT_N_O, FAULT_N_OE, CLIP_OR_HEAT_WARN_N;
  int errors = 0, total_checks = 0, k;
  logic [3:0] r;
  // short current-limit timer keeps the overcurrent case brief
  afs_supervisor #(.OC_TIMER_CYC(8)) afs_supervisor_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .POR_FAULT(gf[0]), .UNDERVOLTAGE(gf[1]), .CHARGE_PUMP_UNDERVOLTAGE(gf[2]),
    .SUPPLY_EXCESS_FAULT(gf[3]), .LOAD_DUMP(gf[4]), .OVERTEMP_WARNING(gf[5]), .OVERTEMP_SHUTDOWN(gf[6]),
    .CLIP_DETECT(CLIP_DETECT), .CYCLE_BY_CYCLE_LIMIT(CYCLE_BY_CYCLE_LIMIT), .DC_DETECT(DC_DETECT),
    .DIAG_RESULT(DIAG_RESULT), .TWEETER_PRESENT(TWEETER_PRESENT), .MUTE_PIN_LEVEL(MUTE_PIN_LEVEL),
    .CMD_HIZ(CMD_HIZ), .CMD_PLAY(CMD_PLAY), .CMD_DIAG_START(CMD_DIAG_START),
    .CMD_TWEETER_DIAG(CMD_TWEETER_DIAG), .CMD_FAULT_CLEAR(CMD_FAULT_CLEAR), .WARN_SEL(WARN_SEL),
    .PLAY_AT_9_10(PLAY_AT_9_10), .MODE(MODE), .CH_HIZ(CH_HIZ), .CH_HARD_MUTE(CH_HARD_MUTE),
    .CUR_LIMIT(CUR_LIMIT), .GAIN(GAIN), .MUTE_DRIVE(MUTE_DRIVE), .GLOBAL_STATUS(GLOBAL_STATUS),
    .OC_STATUS(OC_STATUS), .DC_STATUS(DC_STATUS), .DIAG_STATUS(DIAG_STATUS), .MUTE_ENTERED(MUTE_ENTERED),
    .PLAY_ENTERED(PLAY_ENTERED), .FAULT_N_O(FAULT_N_O), .FAULT_N_OE(FAULT_N_OE),
    .CLIP_OR_HEAT_WARN_N(CLIP_OR_HEAT_WARN_N));
  // far side: mute capacitor
  afs_mute_cap afs_mute_cap_i (.clk(CORE_CLK), .rst_n(RSTN), .drive(MUTE_DRIVE), .level(MUTE_PIN_LEVEL));
  // 50 MHz core clock
  always #10 CORE_CLK = ~CORE_CLK;
  // wait whole cycles, landing on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  // value compare
  task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // single flag compare
  task automatic chkb(input logic got, input logic exp);
    chkv({7'h00, got}, {7'h00, exp});
  endtask
  // one-cycle host clear of latched faults
  task automatic clr();
    CMD_FAULT_CLEAR = 1;
    cyc(1);
    CMD_FAULT_CLEAR = 0;
    cyc(3);
  endtask
  // per-test trailer
  task automatic done(input string n);
    $display("test %s done, errors=%0d", n, errors);
  endtask
  // expected status bit of each global fault the loop raises, zero where only the pin reports it
  function automatic logic [6:0] st_of(input int i);
    case (i)
      1: st_of = 7'h04;
      2: st_of = 7'h08;
      3: st_of = 7'h10;
      6: st_of = 7'h20;
      default: st_of = 7'h00;
    endcase
  endfunction
  // verdict and end of run
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the tests need about 3100 cycles, mostly the three capacitor ramps
  initial
  begin
    repeat (12000) @(posedge CORE_CLK);
    errors++;
    $display("watchdog expired");
    summarize();
  end
  // main sequence
  initial
  begin
    void'($urandom(31));
    cyc(6);
    RSTN = 1;
    cyc(2);
    chkv(MODE, AFS_MUTE);
    chkb(FAULT_N_OE, 1);
    chkb(CLIP_OR_HEAT_WARN_N, 1);
    chkv(GAIN, RST_GAIN);
    done("reset");
    // global faults: raise, drop, clear
    for (int i = 0; i < 7; i++)
    begin
      if (i == 5)
        continue;
      gf[i] = 1;
      cyc(8);
      chkv(GLOBAL_STATUS, st_of(i));
      chkv(MODE, (i == 0 || i == 4 || i == 6) ? AFS_STANDBY : AFS_HIZ);
      chkv(CH_HIZ, 4'hF);
      chkv(CH_HARD_MUTE, (i == 0 || i == 4 || i == 6) ? 4'hF : 4'h0);
      chkb(FAULT_N_OE, 0);
      chkb(FAULT_N_O, 0);
      gf[i] = 0;
      cyc(8);
      chkb(FAULT_N_OE, (i == 0 || i == 4));
      chkv(GLOBAL_STATUS, st_of(i));
      clr();
      cyc(2);
      chkv(GLOBAL_STATUS, 7'h00);
      chkb(FAULT_N_OE, 1);
      chkv(MODE, AFS_MUTE);
    end
    done("global");
    // heat warning on every clip pin source
    for (int s = 0; s < 4; s++)
    begin
      WARN_SEL = s[1:0];
      gf[5] = 1;
      cyc(8);
      chkb(CLIP_OR_HEAT_WARN_N, !s[0]);
      chkb(GLOBAL_STATUS[6], 1);
      chkb(FAULT_N_OE, 1);
      gf[5] = 0;
      cyc(8);
      chkb(GLOBAL_STATUS[6], 0);
      chkb(CLIP_OR_HEAT_WARN_N, 1);
    end
    done("warning");
    // diagnostics, all channels together as a paralleled host would command them
    CMD_HIZ = 4'hF;
    r = 4'($urandom);
    DIAG_RESULT = r;
    CMD_DIAG_START = 1;
    cyc(8);
    chkv(MODE, AFS_HIZ);
    CMD_DIAG_START = 0;
    DIAG_RESULT = 4'h0;
    CMD_TWEETER_DIAG = 1;
    TWEETER_PRESENT = 1;
    cyc(8);
    chkv(DIAG_STATUS, r);
    chkb(CLIP_OR_HEAT_WARN_N, 0);
    chkb(FAULT_N_OE, 1);
    CMD_TWEETER_DIAG = 0;
    TWEETER_PRESENT = 0;
    clr();
    chkv(DIAG_STATUS, 4'h0);
    CMD_HIZ = 4'h0;
    DIAG_RESULT = 4'hF;
    CMD_DIAG_START = 1;
    cyc(8);
    chkv(DIAG_STATUS, 4'h0);
    CMD_DIAG_START = 0;
    DIAG_RESULT = 4'h0;
    done("diag");
    // mute to play, play bit at nine tenths; a run-out limit fails the flag check
    CMD_PLAY = 1;
    cyc(1);
    chkb(MUTE_DRIVE, 1);
    chkv(MODE, AFS_NORMAL);
    for (k = 0; k < 3000 && PLAY_ENTERED !== 1'b1; k++)
      cyc(1);
    chkb(PLAY_ENTERED, 1);
    chkb(MUTE_ENTERED, 0);
    chkb(MUTE_PIN_LEVEL >= THR_9_10, 1);
    chkb(GAIN != 8'h00, 1);
    done("play");
    // clipping and current limit while playing
    WARN_SEL = 2'h2;
    CLIP_DETECT = 4'($urandom_range(15, 1));
    cyc(8);
    chkb(CLIP_OR_HEAT_WARN_N, 0);
    WARN_SEL = 2'h1;
    cyc(3);
    chkb(CLIP_OR_HEAT_WARN_N, 1);
    CLIP_DETECT = 4'h0;
    k = $urandom_range(3, 0);
    CYCLE_BY_CYCLE_LIMIT = 4'h1 << k;
    cyc(5);
    chkv(CUR_LIMIT, 4'h1 << k);
    chkb(CLIP_OR_HEAT_WARN_N, 0);
    CYCLE_BY_CYCLE_LIMIT = 4'h0;
    cyc(8);
    chkv(CUR_LIMIT, 4'h0);
    chkv(OC_STATUS, 4'h0);
    CYCLE_BY_CYCLE_LIMIT = 4'h1 << k;
    cyc(20);
    chkv(OC_STATUS, 4'h1 << k);
    chkb(CH_HIZ[k], 1);
    chkb(CH_HARD_MUTE[k], 1);
    chkb(FAULT_N_OE, 0);
    CYCLE_BY_CYCLE_LIMIT = 4'h0;
    cyc(8);
    chkv(OC_STATUS, 4'h1 << k);
    clr();
    chkv(OC_STATUS, 4'h0);
    chkb(FAULT_N_OE, 1);
    done("current");
    // dc level detect while playing; a clear during the live level loses to it
    r = 4'($urandom_range(15, 1));
    DC_DETECT = r;
    cyc(8);
    chkv(DC_STATUS, r);
    chkv(CH_HIZ, r);
    chkv(CH_HARD_MUTE, r);
    chkb(FAULT_N_OE, 0);
    clr();
    chkv(DC_STATUS, r);
    DC_DETECT = 4'h0;
    cyc(8);
    clr();
    chkv(DC_STATUS, 4'h0);
    done("dc");
    // play to mute, then dc ignored in mute
    CMD_PLAY = 0;
    cyc(1);
    chkb(MUTE_DRIVE, 0);
    for (k = 0; k < 3000 && MUTE_ENTERED !== 1'b1; k++)
      cyc(1);
    chkb(MUTE_ENTERED, 1);
    chkb(PLAY_ENTERED, 0);
    chkb(MUTE_PIN_LEVEL <= THR_1_10, 1);
    chkv(GAIN, 8'h00);
    DC_DETECT = 4'hF;
    cyc(8);
    chkv(DC_STATUS, 4'h0);
    DC_DETECT = 4'h0;
    done("mute");
    // mute to play again with the play bit at two thirds
    PLAY_AT_9_10 = 0;
    CMD_PLAY = 1;
    for (k = 0; k < 3000 && PLAY_ENTERED !== 1'b1; k++)
      cyc(1);
    chkb(PLAY_ENTERED, 1);
    chkb(MUTE_PIN_LEVEL >= THR_2_3 && MUTE_PIN_LEVEL < THR_9_10, 1);
    done("play2");
    summarize();
  end
endmodule
`default_nettype wire
